// >>> verilog/hotplug_slot_control.sv
`timescale 1ns/10ps
// Behaviour
// [R1] Slot control bits 7:6 hold the attention code: 01 on, 10 blink, 11 off, 00 reserved.
// [R2] The blink code drives a 1.5 Hz square wave on the attention indicator.
// [R3] After reset the attention field reads as off, binary 11.
// [R4] Every write to the attention field sends a matching indicator message.
// [R5] For legacy form-factor slots each such write also strobes the virtual pins.
// [R6] Advanced form-factor modules decode the messages themselves, no virtual pins.
// [R7] Bit 5 is the master enable; at zero no hot-plug events or interrupts at all.
// [R8] Bit 4 enables the interrupt on command completion.
// [R9] Bit 3 enables interrupt or wake on presence-detect change.
// [R10] Bit 2 enables interrupt or wake on retention latch sensor change.
// [R11] Bit 1 enables interrupt or wake on power fault.
// [R12] Bit 0 enables interrupt or wake on attention button press.
// [R13] Each write is one command; completion is flagged only if the indicator state changes.
// [R14] Interrupt is raised while an enabled status bit is set with master on, dropped after clear.
// [R15] Legacy mode wire-ORs events into one assert/deassert; message mode sends one per event.
// [R16] Blink comes from a free-running 50 percent divider; steady states follow at once.
module hotplug_slot_control
  import hotplug_slot_control_pkg::*;
#(
  parameter logic [BLINK_CNT_W-1:0] BLINK_HALF = BLINK_CNT_W'(BLINK_HALF_CYCLES)
)
(
  // Clock and reset
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RST_N,
  // Configuration space access
  input  wire logic              I_CFG_WR,
  input  wire logic              I_CFG_RD,
  input  wire logic [11:0]       I_CFG_ADDR,
  input  wire logic [1:0]        I_CFG_BE,
  input  wire logic [15:0]       I_CFG_WDATA,
  output logic      [15:0]       O_CFG_RDATA,
  output logic                   O_CFG_RACK,
  // Slot status and mode
  input  wire logic [EVT_W-1:0]  I_SLOT_STATUS,
  input  wire logic              I_MSI_EN,
  input  wire logic              I_LOW_POWER,
  input  wire logic              I_LEGACY_FORM,
  // Indicator messages and pins
  output logic                   O_ATTN_MSG_VALID,
  output logic      [1:0]        O_ATTN_MSG_CODE,
  output logic                   O_VPIN_VALID,
  output logic      [1:0]        O_VPIN_CODE,
  output logic                   O_ATTN_LED,
  output logic                   O_CMD_DONE,
  // Interrupts and wake
  output logic                   O_HP_IRQ,
  output logic                   O_INTX_ASSERT_MSG,
  output logic                   O_INTX_DEASSERT_MSG,
  output logic                   O_MSI_MSG,
  output logic      [2:0]        O_MSI_EVENT,
  output logic                   O_WAKE_REQ
);

  // ==========================================================================
  // Helpers
  function automatic logic addr_hit(input logic [11:0] addr);
    addr_hit = (addr == SLOT_CTRL_OFFSET);
  endfunction : addr_hit

  function automatic logic [2:0] lowest_set(input logic [EVT_W-1:0] v);
    lowest_set = 3'h0;
    for (int i = EVT_W - 1; i >= 0; i--)
    begin
      if (v[i])
        lowest_set = 3'(i);
    end
  endfunction : lowest_set

  // ==========================================================================
  // Declarations
  logic [1:0]       attn_field;
  logic             master_en;
  logic [EVT_W-1:0] evt_en;
  logic             blink_phase;
  logic             write_attn;
  logic [EVT_W-1:0] prev_status;
  logic [EVT_W-1:0] new_evt;
  logic [EVT_W-1:0] msi_pend;
  logic [EVT_W-1:0] msi_sent;
  logic [EVT_W-1:0] next_msi_pend;
  logic             next_irq;
  logic             legacy_level;
  intx_state_t      intx_state;

  // Write strobe for the low byte of slot control
  assign write_attn = I_CFG_WR && addr_hit(I_CFG_ADDR) && I_CFG_BE[0];

  // ==========================================================================
  // Control register
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      attn_field <= ATTN_RESET; // [R3]
      master_en  <= MASTER_RESET;
      evt_en     <= EVT_EN_RESET;
    end
    else if (write_attn)
    begin
      attn_field <= I_CFG_WDATA[ATTN_MSB:ATTN_LSB]; // [R1]
      master_en  <= I_CFG_WDATA[MASTER_EN_BIT]; // [R7]
      evt_en     <= I_CFG_WDATA[EVT_W-1:0]; // [R8] [R9] [R10] [R11] [R12]
    end
  end

  // Read port, unmapped offsets give no acknowledge
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      O_CFG_RDATA <= 16'h0000;
      O_CFG_RACK  <= 1'b0;
    end
    else
    begin
      O_CFG_RACK  <= I_CFG_RD && addr_hit(I_CFG_ADDR);
      O_CFG_RDATA <= (I_CFG_RD && addr_hit(I_CFG_ADDR)) ?
                     ({8'h00, attn_field, master_en, evt_en} & SLOT_CTRL_RD_MASK) : 16'h0000;
    end
  end

  // ==========================================================================
  // Indicator messages, virtual pins and command completion
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      O_ATTN_MSG_VALID <= 1'b0;
      O_ATTN_MSG_CODE  <= ATTN_RESET;
      O_VPIN_VALID     <= 1'b0;
      O_VPIN_CODE      <= ATTN_RESET;
      O_CMD_DONE       <= 1'b0;
    end
    else
    begin
      O_ATTN_MSG_VALID <= write_attn; // [R4]
      O_VPIN_VALID     <= write_attn && I_LEGACY_FORM; // [R5] [R6]
      O_CMD_DONE       <= write_attn &&
                          (I_CFG_WDATA[ATTN_MSB:ATTN_LSB] != attn_field); // [R13]
      if (write_attn)
      begin
        O_ATTN_MSG_CODE <= I_CFG_WDATA[ATTN_MSB:ATTN_LSB];
        if (I_LEGACY_FORM)
        begin
          O_VPIN_CODE <= I_CFG_WDATA[ATTN_MSB:ATTN_LSB];
        end
      end
    end
  end

  // ==========================================================================
  // Attention indicator drive
  blink_divider #(
    .HALF_CYCLES (BLINK_HALF)
  ) u_blink (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .o_phase (blink_phase)
  );

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      O_ATTN_LED <= 1'b0;
    end
    else
    begin
      case (attn_field)
        ATTN_ON:    O_ATTN_LED <= 1'b1; // [R16]
        ATTN_BLINK: O_ATTN_LED <= blink_phase; // [R2]
        default:    O_ATTN_LED <= 1'b0; // Off and reserved code
      endcase
    end
  end

  // ==========================================================================
  // Interrupt level and event detection
  always_comb
  begin
    next_irq      = master_en && (|(I_SLOT_STATUS & evt_en)); // [R14] [R7]
    legacy_level  = next_irq && !I_MSI_EN;
    new_evt       = I_SLOT_STATUS & ~prev_status & evt_en & {EVT_W{master_en}};
    msi_sent      = '0;
    if (|msi_pend)
      msi_sent[lowest_set(msi_pend)] = 1'b1;
    next_msi_pend = (msi_pend & ~msi_sent) | (new_evt & {EVT_W{I_MSI_EN}});
  end

  // Status history and combined level
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      prev_status <= '0;
      O_HP_IRQ    <= 1'b0;
      O_WAKE_REQ  <= 1'b0;
    end
    else
    begin
      prev_status <= I_SLOT_STATUS;
      O_HP_IRQ    <= next_irq; // [R14]
      O_WAKE_REQ  <= I_LOW_POWER && (|new_evt[PRESENCE_BIT:BUTTON_BIT]); // [R9] [R10] [R11] [R12]
    end
  end

  // Legacy wired-OR: one assert, one deassert
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      intx_state          <= INTX_IDLE;
      O_INTX_ASSERT_MSG   <= 1'b0;
      O_INTX_DEASSERT_MSG <= 1'b0;
    end
    else
    begin
      O_INTX_ASSERT_MSG   <= 1'b0;
      O_INTX_DEASSERT_MSG <= 1'b0;
      case (intx_state)
        INTX_IDLE:
        begin
          if (legacy_level)
          begin
            intx_state        <= INTX_ASSERTED;
            O_INTX_ASSERT_MSG <= 1'b1; // [R15]
          end
        end
        INTX_ASSERTED:
        begin
          if (!legacy_level)
          begin
            intx_state          <= INTX_IDLE;
            O_INTX_DEASSERT_MSG <= 1'b1; // [R15]
          end
        end
        default: intx_state <= INTX_IDLE;
      endcase
    end
  end

  // Message mode: one message per new event bit
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      msi_pend    <= '0;
      O_MSI_MSG   <= 1'b0;
      O_MSI_EVENT <= 3'h0;
    end
    else
    begin
      msi_pend  <= next_msi_pend; // [R15]
      O_MSI_MSG <= |msi_pend;
      if (|msi_pend)
        O_MSI_EVENT <= lowest_set(msi_pend);
    end
  end

  // ==========================================================================
  // Assertions
  property p_reset_off;
    @(posedge I_REF_CLK) !I_RST_N |=> (attn_field == ATTN_OFF);
  endproperty
  a_reset_off: assert property (p_reset_off) // [R3]
    else $error("attention field not off after reset");
  property p_read_field;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CFG_RD && addr_hit(I_CFG_ADDR)) |=>
        O_CFG_RACK && (O_CFG_RDATA[ATTN_MSB:ATTN_LSB] == $past(attn_field));
  endproperty
  a_read_field: assert property (p_read_field) // [R1]
    else $error("read of attention field wrong");
  property p_msg_on_write;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      write_attn |=> O_ATTN_MSG_VALID &&
        (O_ATTN_MSG_CODE == $past(I_CFG_WDATA[ATTN_MSB:ATTN_LSB])) && (attn_field == O_ATTN_MSG_CODE);
  endproperty
  a_msg_on_write: assert property (p_msg_on_write) // [R4]
    else $error("indicator message missing or wrong");
  property p_vpin_legacy;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      O_VPIN_VALID |-> $past(I_LEGACY_FORM) && O_ATTN_MSG_VALID && (O_VPIN_CODE == O_ATTN_MSG_CODE);
  endproperty
  a_vpin_legacy: assert property (p_vpin_legacy) // [R5] [R6]
    else $error("virtual pin strobe without legacy slot");
  property p_cmd_done;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      O_CMD_DONE |-> $past(write_attn) && (attn_field != $past(attn_field));
  endproperty
  a_cmd_done: assert property (p_cmd_done) // [R13]
    else $error("command completion without indicator change");
  property p_irq_cause;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      O_HP_IRQ |-> $past(master_en) && (|($past(I_SLOT_STATUS) & $past(evt_en)));
  endproperty
  a_irq_cause: assert property (p_irq_cause) // [R7] [R8] [R14]
    else $error("interrupt without enabled status");
  property p_irq_raise;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (master_en && (|(I_SLOT_STATUS & evt_en))) |=> O_HP_IRQ;
  endproperty
  a_irq_raise: assert property (p_irq_raise) // [R14]
    else $error("enabled status did not raise interrupt");
  property p_wake_cause;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      O_WAKE_REQ |-> $past(master_en && I_LOW_POWER) &&
        (|($past(I_SLOT_STATUS[PRESENCE_BIT:BUTTON_BIT]) & $past(evt_en[PRESENCE_BIT:BUTTON_BIT])));
  endproperty
  a_wake_cause: assert property (p_wake_cause) // [R9] [R10] [R11] [R12]
    else $error("wake request without enabled event");
  property p_blink;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (attn_field == ATTN_BLINK) |=> (O_ATTN_LED == $past(blink_phase));
  endproperty
  a_blink: assert property (p_blink) // [R2]
    else $error("blink output does not follow divider");
  property p_steady;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (attn_field != ATTN_BLINK) |=> (O_ATTN_LED == ($past(attn_field) == ATTN_ON));
  endproperty
  a_steady: assert property (p_steady) // [R16]
    else $error("steady indicator state wrong");
  property p_intx_assert;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (intx_state == INTX_IDLE && legacy_level) |=> O_INTX_ASSERT_MSG ##1 !O_INTX_ASSERT_MSG;
  endproperty
  a_intx_assert: assert property (p_intx_assert) // [R15]
    else $error("legacy assert message not single");
  property p_msi_mode;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_MSI_EN && new_evt[BUTTON_BIT] && !msi_pend[BUTTON_BIT]) |=> ##[0:5] O_MSI_MSG;
  endproperty
  a_msi_mode: assert property (p_msi_mode) // [R15]
    else $error("new event sent no message");
  c_blink: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    attn_field == ATTN_BLINK && O_ATTN_LED);
  c_cmd_done: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N) O_CMD_DONE);
  c_intx: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_INTX_ASSERT_MSG ##[1:20] O_INTX_DEASSERT_MSG);
  c_msi_two: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_MSI_MSG ##1 O_MSI_MSG);
endmodule : hotplug_slot_control

// >>> verilog/hotplug_slot_control_pkg.sv
package hotplug_slot_control_pkg;
  // ==========================================================================
  // Register placement
  localparam logic [11:0] SLOT_CTRL_OFFSET = 12'h084;
  localparam logic [15:0] SLOT_CTRL_RD_MASK = 16'h00FF; // Upper bits read zero

  // ==========================================================================
  // Field positions
  localparam int ATTN_LSB        = 6;
  localparam int ATTN_MSB        = 7;
  localparam int MASTER_EN_BIT   = 5;
  localparam int CMD_DONE_BIT    = 4;
  localparam int PRESENCE_BIT    = 3;
  localparam int LATCH_BIT       = 2;
  localparam int POWER_FAULT_BIT = 1;
  localparam int BUTTON_BIT      = 0;
  localparam int EVT_W           = 5;

  // ==========================================================================
  // Attention indicator codes
  localparam logic [1:0] ATTN_RSVD  = 2'h0;
  localparam logic [1:0] ATTN_ON    = 2'h1;
  localparam logic [1:0] ATTN_BLINK = 2'h2;
  localparam logic [1:0] ATTN_OFF   = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic [1:0]       ATTN_RESET   = ATTN_OFF;
  localparam logic [EVT_W-1:0] EVT_EN_RESET = 5'h00;
  localparam logic             MASTER_RESET = 1'b0;

  // ==========================================================================
  // Timing
  localparam longint CLK_HZ            = 200000000;
  localparam longint BLINK_HZ_X10      = 15; // 1.5 Hz in tenths
  localparam longint BLINK_HALF_CYCLES = (CLK_HZ * 10) / (2 * BLINK_HZ_X10);
  localparam int     BLINK_CNT_W       = 27;

  // ==========================================================================
  // Legacy interrupt states
  typedef enum logic [0:0] {INTX_IDLE, INTX_ASSERTED} intx_state_t;
endpackage : hotplug_slot_control_pkg

// >>> verilog/blink_divider.sv
`timescale 1ns/10ps
module blink_divider
  import hotplug_slot_control_pkg::*;
#(
  parameter logic [BLINK_CNT_W-1:0] HALF_CYCLES = BLINK_CNT_W'(BLINK_HALF_CYCLES)
)
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Square wave phase
  output logic      o_phase
);
  logic [BLINK_CNT_W-1:0] count;

  // ==========================================================================
  // Free-running half-period counter, phase toggles at each wrap
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      count   <= '0;
      o_phase <= 1'b0;
    end
    else if (count >= HALF_CYCLES - 1'b1)
    begin
      count   <= '0;
      o_phase <= ~o_phase;
    end
    else
    begin
      count <= count + 1'b1;
    end
  end
endmodule : blink_divider

// >>> bench/slot_card_model.sv
`timescale 1ns/10ps
module slot_card_model
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Events and clears from the bench
  input  wire logic [4:0] i_set,
  input  wire logic [4:0] i_clr,
  // Requests from the port
  input  wire logic       i_cmd_done,
  input  wire logic       i_msg_valid,
  input  wire logic [1:0] i_msg_code,
  // Status and decoded indicator
  output logic      [4:0] o_status,
  output logic      [1:0] o_led_state
);
  // ==========================================================================
  // Status bits, a new event wins over a clear
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_status <= 5'h00;
    else
      o_status <= (o_status & ~i_clr) | i_set | {i_cmd_done, 4'h0};
  end

  // Indicator state decoded from messages alone
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_led_state <= 2'h3;
    else if (i_msg_valid)
      o_led_state <= i_msg_code;
  end
endmodule : slot_card_model

// >>> bench/hotplug_slot_control_tb_top.sv
`timescale 1ns/10ps
module hotplug_slot_control_tb_top;
  import hotplug_slot_control_pkg::*;
  // ==========================================================================
  // Signals
  logic        clk, rst_n, wr, rd, msi_en, low_pwr, legacy;
  logic [11:0] addr;
  logic [1:0]  be, m_code, vp_code, card_state;
  logic [15:0] wdata, rdata, d;
  logic [4:0]  status, ev_set, ev_clr;
  logic        rack, m_v, vp_v, led, cmd_done, irq, a_msg, d_msg, msi, wake, ack;
  logic [2:0]  msi_ev;
  int          error_cnt, check_count;

  // ==========================================================================
  // Block and slot card
  hotplug_slot_control #(.BLINK_HALF(27'h4)) i_dut (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_CFG_WR(wr), .I_CFG_RD(rd),
    .I_CFG_ADDR(addr), .I_CFG_BE(be), .I_CFG_WDATA(wdata),
    .O_CFG_RDATA(rdata), .O_CFG_RACK(rack), .I_SLOT_STATUS(status),
    .I_MSI_EN(msi_en), .I_LOW_POWER(low_pwr), .I_LEGACY_FORM(legacy),
    .O_ATTN_MSG_VALID(m_v), .O_ATTN_MSG_CODE(m_code), .O_VPIN_VALID(vp_v),
    .O_VPIN_CODE(vp_code), .O_ATTN_LED(led), .O_CMD_DONE(cmd_done),
    .O_HP_IRQ(irq), .O_INTX_ASSERT_MSG(a_msg), .O_INTX_DEASSERT_MSG(d_msg),
    .O_MSI_MSG(msi), .O_MSI_EVENT(msi_ev), .O_WAKE_REQ(wake));
  slot_card_model i_card (
    .i_clk(clk), .i_rst_n(rst_n), .i_set(ev_set), .i_clr(ev_clr),
    .i_cmd_done(cmd_done), .i_msg_valid(m_v), .i_msg_code(m_code),
    .o_status(status), .o_led_state(card_state));

  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cfg_write(input logic [11:0] a, input logic [15:0] v, input logic [1:0] b);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    be <= b;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : cfg_write

  task automatic cfg_read(input logic [11:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    ack = rack;
    d = rdata;
  endtask : cfg_read

  task automatic pulse(input logic [4:0] s, input logic [4:0] c);
    @(posedge clk);
    ev_set <= s;
    ev_clr <= c;
    @(posedge clk);
    ev_set <= 5'h00;
    ev_clr <= 5'h00;
    #1;
  endtask : pulse

  function automatic logic sel(input int which);
    case (which)
      0: sel = irq;
      1: sel = msi;
      default: sel = wake;
    endcase
  endfunction : sel

  task automatic wait_for(input int which, input logic val);
    int n;
    n = 0;
    while (sel(which) !== val && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_for

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    cfg_read(12'h084);
    check("reset ack", ack, 1'b1);
    check("reset value", d, 16'h00C0);
    check("reset led", led, 1'b0);
    cfg_write(12'h088, 16'h003F, 2'h3);
    cfg_write(12'h084, 16'h0040, 2'h2);
    cfg_read(12'h084);
    check("ignored writes", d, 16'h00C0);
    cfg_read(12'h088);
    check("unmapped ack", ack, 1'b0);
  endtask : t_reset

  task automatic t_codes;
    logic [1:0] codes [5];
    logic [1:0] prev;
    codes = '{ATTN_ON, ATTN_BLINK, ATTN_BLINK, ATTN_RSVD, ATTN_OFF};
    prev = ATTN_OFF;
    foreach (codes[k])
    begin
      cfg_write(12'h084, {8'h00, codes[k], 6'h00}, 2'h3);
      check("msg valid", m_v, 1'b1);
      check("msg code", m_code, codes[k]);
      check("vpin valid", vp_v, 1'b1);
      check("vpin code", vp_code, codes[k]);
      check("cmd done", cmd_done, codes[k] != prev);
      cfg_read(12'h084);
      check("attn field", d, {8'h00, codes[k], 6'h00});
      check("card state", card_state, codes[k]);
      if (codes[k] != ATTN_BLINK)
        check("steady led", led, codes[k] == ATTN_ON);
      prev = codes[k];
    end
    @(posedge clk);
    legacy <= 1'b0;
    cfg_write(12'h084, 16'h00C0, 2'h1);
    check("msg no vpin", m_v, 1'b1);
    check("vpin off", vp_v, 1'b0);
    check("same code", cmd_done, 1'b0);
  endtask : t_codes

  task automatic t_blink;
    logic l;
    int   run;
    cfg_write(12'h084, 16'h0080, 2'h3);
    for (int k = 0; k < 3; k++)
    begin
      l = led;
      run = 0;
      while (led === l && run < 20)
      begin
        @(posedge clk);
        #1;
        run++;
      end
      if (k > 0)
        check("blink half", 16'(run), 16'h0004);
    end
    cfg_write(12'h084, 16'h0040, 2'h3);
    @(posedge clk);
    #1;
    check("led on", led, 1'b1);
    cfg_write(12'h084, 16'h00C0, 2'h3);
    @(posedge clk);
    #1;
    check("led off", led, 1'b0);
  endtask : t_blink

  task automatic t_irq;
    cfg_write(12'h084, 16'h00FF, 2'h3);
    pulse(5'h00, 5'h1F);
    for (int i = 0; i < 5; i++)
    begin
      pulse(5'h01 << i, 5'h00);
      wait_for(0, 1'b1);
      check("irq up", irq, 1'b1);
      check("assert msg", a_msg, 1'b1);
      pulse(5'h00, 5'h1F);
      wait_for(0, 1'b0);
      check("irq down", irq, 1'b0);
      check("deassert msg", d_msg, 1'b1);
    end
    pulse(5'h03, 5'h00);
    wait_for(0, 1'b1);
    pulse(5'h00, 5'h01);
    repeat (3) @(posedge clk);
    #1;
    check("wired or", irq, 1'b1);
    pulse(5'h00, 5'h1F);
    wait_for(0, 1'b0);
    // Master off first, then latch enable off
    for (int k = 0; k < 2; k++)
    begin
      cfg_write(12'h084, (k == 0) ? 16'h00DF : 16'h00FB, 2'h3);
      pulse(5'h04, 5'h00);
      repeat (4) @(posedge clk);
      #1;
      check("irq masked", irq, 1'b0);
      pulse(5'h00, 5'h1F);
    end
  endtask : t_irq

  task automatic t_msi;
    cfg_write(12'h084, 16'h00FF, 2'h3);
    @(posedge clk);
    msi_en <= 1'b1;
    pulse(5'h09, 5'h00);
    wait_for(1, 1'b1);
    check("msi up", msi, 1'b1);
    check("msi first", msi_ev, 3'h0);
    @(posedge clk);
    #1;
    check("msi second", msi, 1'b1);
    check("msi event", msi_ev, 3'h3);
    pulse(5'h00, 5'h1F);
    @(posedge clk);
    low_pwr <= 1'b1;
    pulse(5'h08, 5'h00);
    wait_for(2, 1'b1);
    check("wake", wake, 1'b1);
  endtask : t_msi

  // Reset in mid-run, then events with the master enable cleared
  task automatic t_rerun;
    cfg_write(12'h084, 16'h007F, 2'h3);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cfg_read(12'h084);
    check("rerun value", d, 16'h00C0);
    check("rerun led", led, 1'b0);
    pulse(5'h08, 5'h00);
    @(posedge clk);
    #1;
    check("master off irq", irq, 1'b0);
    check("master off wake", wake, 1'b0);
    @(posedge clk);
    #1;
    check("master off msi", msi, 1'b0);
  endtask : t_rerun

  // ==========================================================================
  // Verdict
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end

  // Main sequence
  initial
  begin
    error_cnt = 0;
    check_count = 0;
    {rst_n, wr, rd, msi_en, low_pwr} = 5'h00;
    legacy = 1'b1;
    addr = 12'h084;
    be = 2'h3;
    wdata = 16'h0000;
    ev_set = 5'h00;
    ev_clr = 5'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_codes;
    t_blink;
    t_irq;
    t_msi;
    t_rerun;
    report_and_stop;
  end
endmodule : hotplug_slot_control_tb_top
